// file: efa_cfg.svh
`ifndef EFA_CFG_SVH
`define EFA_CFG_SVH
// register offsets (byte addresses on the plain port)
`define EFA_ADDR_W        8
`define EFA_OFS_ALARM_EN  8'h23
`define EFA_OFS_FRM_IND   8'h24
`define EFA_OFS_ALM_IND   8'h25
`define EFA_OFS_FRM_STAT  8'h26
`define EFA_OFS_ALM_STAT  8'h27
`define EFA_RST_BYTE      8'h00
// framing status/control bit positions
`define EFA_BIT_FRAME_LOSS 6
`define EFA_BIT_SIG_LOSS   5
`define EFA_BIT_CRC_LOSS   4
`define EFA_BIT_TIMER_DIS  1
`define EFA_BIT_MFPAT_DIS  0
// timing
`define EFA_CLK_MHZ       200
`define EFA_HOLD_MS       100
`define EFA_MF_SEARCH_MS  8
`define EFA_MFPAT_ERR_MAX 3'h4
`define EFA_UNF_BITS      10'h200
`define EFA_UNF_ZERO_MAX  2'h3
`define EFA_DEB_SHORT     2'h2
`define EFA_DEB_LONG      2'h3
`define EFA_SLOT16_CNT    2'h2
`endif

// file: efa_pkg.sv
package efa_pkg;
    typedef enum logic [1:0] {
        EFA_AL_SYNC   = 2'b00,
        EFA_AL_HUNT   = 2'b01,
        EFA_AL_MFHUNT = 2'b10
    } efa_align_type;
    typedef logic [7:0] efa_byte_type;
endpackage

// file: efa_persist.sv
`timescale 1ns/100ps
`include "efa_cfg.svh"
// output follows the input once it has held its new level for HOLD_CYC cycles
module efa_persist #(
    parameter int HOLD_CYC = 20000000
) (
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    input  wire logic cond_in,
    output logic      level_out
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        lvl;
    } efa_persist_state_type;
    efa_persist_state_type st_r;
    efa_persist_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (cond_in == st_r.lvl) begin
            st_nxt.cnt = 32'h0;
        end else if (st_r.cnt >= 32'(HOLD_CYC - 1)) begin
            st_nxt.cnt = 32'h0;
            st_nxt.lvl = cond_in;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.lvl;
endmodule

// file: efa_alarm.sv
`timescale 1ns/100ps
`include "efa_cfg.svh"
// Functional notes
// - alarm change enables gate interrupt on toggle
// - far block error enable raises interrupt
// - crc mismatch enable raises interrupt
// - zero in Si of frame 13/15 sets flag
// - single crc mismatch sets flag
// - framing change flags set on either edge
// - pattern error flags latch since last read
// - flags set regardless of enables
// - framing indication read clears, drops interrupt
// - alarm indication read clears, drops interrupt
// - alarm change flags set on toggle
// - frame loss status while alignment lost
// - signalling multiframe loss status while lost
// - crc multiframe loss status while lost
// - 8 ms search timer forces reframe unless disabled
// - four bad patterns drop crc mf, frame
// - disabled: crc mf held until frame loss/excess
// - far alarm debounced 2/3 non-alignment frames
// - far mf alarm debounced 2/3 multiframes
// - unframed ones: under 3 zeros per 512
// - slot16 ones: two frames while sig lost
// - sustained loss after 100 ms, same release
// - all ones alarm 100 ms set/clear
// - debounce setting picks 2 or 3
module efa_alarm
    import efa_pkg::*;
#(
    parameter int HOLD_CYC   = `EFA_HOLD_MS * `EFA_CLK_MHZ * 1000,
    parameter int SEARCH_CYC = `EFA_MF_SEARCH_MS * `EFA_CLK_MHZ * 1000
) (
    input  wire logic                     mclk_in,
    input  wire logic                     arst_n_in,
    input  wire logic [`EFA_ADDR_W-1:0]   addr_in,
    input  wire efa_pkg::efa_byte_type    wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    output efa_pkg::efa_byte_type         rdata_out,
    input  wire logic                     rx_bit_in,
    input  wire logic                     bit_stb_in,
    input  wire logic                     nfas_stb_in,
    input  wire logic                     mf0_stb_in,
    input  wire logic                     slot16_stb_in,
    input  wire efa_pkg::efa_byte_type    slot16_byte_in,
    input  wire logic                     si_stb_in,
    input  wire logic                     frame_lock_in,
    input  wire logic                     sig_mf_lock_in,
    input  wire logic                     crc_mf_found_in,
    input  wire logic                     align_move_in,
    input  wire logic                     fas_err_in,
    input  wire logic                     sig_pat_err_in,
    input  wire logic                     crc_pat_err_in,
    input  wire logic                     crc_mismatch_in,
    input  wire logic                     excess_crc_in,
    input  wire logic                     ones_cond_in,
    input  wire logic                     far_alarm_debounce_in,
    input  wire logic                     far_mf_alarm_debounce_in,
    input  wire efa_pkg::efa_byte_type    frame_irq_en_in,
    output logic                          reframe_out,
    output logic                          irq_out
);
    import efa_pkg::*;

    typedef struct packed {
        efa_byte_type  en;
        efa_byte_type  frm_ind;
        efa_byte_type  alm_ind;
        logic [1:0]    ctl;
        logic          crc_lost;
        logic          pat_oof;
        logic [2:0]    pat_cnt;
        logic [31:0]   search;
        logic          reframe;
        logic [1:0]    fa_cnt;
        logic          fa_val;
        logic          fa_stat;
        logic          fa_phase;
        logic [1:0]    fm_cnt;
        logic          fm_val;
        logic          fm_stat;
        logic [9:0]    unf_bits;
        logic [1:0]    unf_zeros;
        logic          unf_stat;
        logic [1:0]    s16_cnt;
        logic          s16_stat;
        logic [5:0]    st_d;
        logic [3:0]    frm_d;
        efa_byte_type  rdata;
    } efa_alarm_state_type;

    efa_alarm_state_type st_r;
    efa_alarm_state_type st_nxt;
    logic                red_lvl;
    logic                ais_lvl;
    logic                frame_loss_status;
    logic                sig_mf_loss_status;
    logic                crc_mf_loss_status;
    logic [5:0]          alm_stat;
    logic [3:0]          frm_src;
    logic [1:0]          deb_need;
    logic [1:0]          mdeb_need;

    efa_persist #(.HOLD_CYC(HOLD_CYC)) u_red (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .cond_in   (frame_loss_status),
        .level_out (red_lvl)
    );

    efa_persist #(.HOLD_CYC(HOLD_CYC)) u_ais (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .cond_in   (ones_cond_in & frame_loss_status),
        .level_out (ais_lvl)
    );

    // pattern-loss forces frame loss too, so loss follows both sources
    assign frame_loss_status  = ~frame_lock_in | st_r.pat_oof;
    assign sig_mf_loss_status = ~sig_mf_lock_in;
    assign crc_mf_loss_status = st_r.crc_lost;
    assign alm_stat = {st_r.fa_stat, st_r.fm_stat, st_r.unf_stat, st_r.s16_stat, red_lvl, ais_lvl};
    assign frm_src  = {frame_loss_status, sig_mf_loss_status, crc_mf_loss_status, align_move_in};
    assign deb_need  = far_alarm_debounce_in ? `EFA_DEB_LONG : `EFA_DEB_SHORT;
    assign mdeb_need = far_mf_alarm_debounce_in ? `EFA_DEB_LONG : `EFA_DEB_SHORT;

    always_comb begin
        logic rd_frm;
        logic rd_alm;
        efa_byte_type frm_set;
        efa_byte_type alm_set;
        rd_frm  = rd_in && (addr_in == `EFA_OFS_FRM_IND);
        rd_alm  = rd_in && (addr_in == `EFA_OFS_ALM_IND);
        frm_set = '0;
        alm_set = '0;
        st_nxt  = st_r;
        st_nxt.st_d  = alm_stat;
        st_nxt.frm_d = {frame_loss_status, sig_mf_loss_status, crc_mf_loss_status, 1'b0};
        st_nxt.reframe = 1'b0;

        // register writes
        if (wr_in && addr_in == `EFA_OFS_ALARM_EN) begin
            st_nxt.en = wdata_in;
        end
        if (wr_in && addr_in == `EFA_OFS_FRM_STAT) begin
            st_nxt.ctl = {wdata_in[`EFA_BIT_TIMER_DIS], wdata_in[`EFA_BIT_MFPAT_DIS]};
        end

        // crc multiframe loss and search timer
        if (!st_r.crc_lost) begin
            if (crc_pat_err_in && !st_r.ctl[0]) begin
                st_nxt.pat_cnt = st_r.pat_cnt + 3'h1;
                if (st_r.pat_cnt + 3'h1 >= `EFA_MFPAT_ERR_MAX) begin
                    st_nxt.crc_lost = 1'b1;
                    st_nxt.pat_oof  = 1'b1;
                end
            end else if (crc_mf_found_in) begin
                // a good pattern breaks the run; gaps between patterns do not
                st_nxt.pat_cnt = 3'h0;
            end
            if (!frame_lock_in || excess_crc_in) begin
                st_nxt.crc_lost = 1'b1;
            end
            st_nxt.search = 32'h0;
        end else begin
            st_nxt.pat_cnt = 3'h0;
            if (crc_mf_found_in && frame_lock_in) begin
                st_nxt.crc_lost = 1'b0;
                st_nxt.pat_oof  = 1'b0;
                st_nxt.search   = 32'h0;
            end else if (st_r.search >= 32'(SEARCH_CYC - 1)) begin
                st_nxt.search  = 32'h0;
                st_nxt.reframe = ~st_r.ctl[1];
            end else begin
                st_nxt.search = st_r.search + 32'h1;
            end
        end

        // far alarm bit, sampled each non-alignment frame, updated every two
        if (nfas_stb_in) begin
            st_nxt.fa_phase = ~st_r.fa_phase;
            if (rx_bit_in == st_r.fa_val) begin
                if (st_r.fa_cnt != 2'h3) st_nxt.fa_cnt = st_r.fa_cnt + 2'h1;
            end else begin
                st_nxt.fa_val = rx_bit_in;
                st_nxt.fa_cnt = 2'h1;
            end
            if (st_r.fa_phase && st_nxt.fa_cnt >= deb_need) begin
                st_nxt.fa_stat = st_nxt.fa_val;
            end
        end
        // far multiframe alarm bit, once per signalling multiframe
        if (mf0_stb_in) begin
            if (slot16_byte_in[2] == st_r.fm_val) begin
                if (st_r.fm_cnt != 2'h3) st_nxt.fm_cnt = st_r.fm_cnt + 2'h1;
            end else begin
                st_nxt.fm_val = slot16_byte_in[2];
                st_nxt.fm_cnt = 2'h1;
            end
            if (st_nxt.fm_cnt >= mdeb_need) begin
                st_nxt.fm_stat = st_nxt.fm_val;
            end
        end
        // unframed ones over 512-bit windows
        if (bit_stb_in) begin
            if (!rx_bit_in && st_r.unf_zeros != 2'h3) begin
                st_nxt.unf_zeros = st_r.unf_zeros + 2'h1;
            end
            if (st_r.unf_bits == `EFA_UNF_BITS - 10'h1) begin
                st_nxt.unf_bits  = 10'h0;
                st_nxt.unf_stat  = (st_nxt.unf_zeros < `EFA_UNF_ZERO_MAX);
                st_nxt.unf_zeros = 2'h0;
            end else begin
                st_nxt.unf_bits = st_r.unf_bits + 10'h1;
            end
        end
        // slot 16 all ones while out of signalling multiframe
        if (slot16_stb_in) begin
            if (slot16_byte_in == 8'hFF && sig_mf_loss_status) begin
                if (st_r.s16_cnt != `EFA_SLOT16_CNT) st_nxt.s16_cnt = st_r.s16_cnt + 2'h1;
            end else begin
                st_nxt.s16_cnt = 2'h0;
            end
            st_nxt.s16_stat = (st_nxt.s16_cnt == `EFA_SLOT16_CNT);
        end

        // indication sources, independent of enables
        frm_set[6:3] = (frm_src ^ st_r.frm_d) & 4'hE | {3'h0, align_move_in};
        frm_set[2]   = fas_err_in;
        frm_set[1]   = sig_pat_err_in;
        frm_set[0]   = crc_pat_err_in;
        alm_set[7:2] = alm_stat ^ st_r.st_d;
        alm_set[1]   = si_stb_in & ~rx_bit_in;
        alm_set[0]   = crc_mismatch_in;

        // set wins over the read clear
        st_nxt.frm_ind = (rd_frm ? 8'h00 : st_r.frm_ind) | frm_set;
        st_nxt.alm_ind = (rd_alm ? 8'h00 : st_r.alm_ind) | alm_set;

        // read data
        st_nxt.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `EFA_OFS_ALARM_EN: st_nxt.rdata = st_r.en;
                `EFA_OFS_FRM_IND:  st_nxt.rdata = {1'b0, st_r.frm_ind[6:0]};
                `EFA_OFS_ALM_IND:  st_nxt.rdata = st_r.alm_ind;
                `EFA_OFS_FRM_STAT: st_nxt.rdata = {1'b0, frame_loss_status, sig_mf_loss_status,
                                                   crc_mf_loss_status, 2'b00, st_r.ctl};
                `EFA_OFS_ALM_STAT: st_nxt.rdata = {alm_stat, 2'b00};
                default:           st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r          <= '0;
            st_r.crc_lost <= 1'b1;
            // lock pins idle high, so no false change flag after reset
            st_r.frm_d    <= 4'h2;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out   = st_r.rdata;
    assign reframe_out = st_r.reframe;
    // enables gate the latched flags onto the interrupt only
    assign irq_out = |(st_r.alm_ind & st_r.en) |
                     |(st_r.frm_ind[6:0] & frame_irq_en_in[6:0]);

    property p_rdclr(logic hit, logic [7:0] ind);
        @(posedge mclk_in) disable iff (!arst_n_in)
        hit |=> (ind == 8'h00) || $changed(alm_stat) || crc_mismatch_in || si_stb_in ||
                $past(crc_mismatch_in) || $past(si_stb_in) || $past(alm_stat != st_r.st_d);
    endproperty
    AST_ALM_CLEAR: assert property (p_rdclr(rd_in && addr_in == `EFA_OFS_ALM_IND &&
        !(|{crc_mismatch_in, si_stb_in}) && alm_stat == st_r.st_d, st_r.alm_ind))
        else $error("alarm indication not cleared by read");
    AST_CRC_SET: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        crc_mismatch_in |=> st_r.alm_ind[0])
        else $error("crc mismatch flag not set");
    AST_IRQ: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.alm_ind[0] && st_r.en[0]) |-> irq_out)
        else $error("crc irq missing");
    AST_TOGGLE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        $changed(red_lvl) |=> st_r.alm_ind[3])
        else $error("sustained loss change not flagged");
    AST_FRM_ERR: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        fas_err_in |=> st_r.frm_ind[2])
        else $error("frame pattern error not latched");
    AST_OOF: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        !frame_lock_in |-> frame_loss_status)
        else $error("frame loss status wrong");
    AST_FEBE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (si_stb_in && !rx_bit_in) |=> st_r.alm_ind[1])
        else $error("far block error not flagged");
    AST_NOIRQ: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.en == 8'h00 && frame_irq_en_in == 8'h00) |-> !irq_out)
        else $error("irq with all enables off");

    sequence s_frm_rd_quiet;
        rd_in && addr_in == `EFA_OFS_FRM_IND && frm_src[3:1] == st_r.frm_d[3:1] &&
        !(|{align_move_in, fas_err_in, sig_pat_err_in, crc_pat_err_in});
    endsequence
    sequence s_mf_fourth;
        !st_r.crc_lost && !st_r.ctl[0] && crc_pat_err_in &&
        st_r.pat_cnt == `EFA_MFPAT_ERR_MAX - 3'h1;
    endsequence
    sequence s_search_end;
        st_r.crc_lost && !(crc_mf_found_in && frame_lock_in) &&
        st_r.search == 32'(SEARCH_CYC - 1);
    endsequence
    AST_FRM_CLEAR: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        s_frm_rd_quiet |=> st_r.frm_ind == 8'h00)
        else $error("framing indication not cleared by read");
    AST_MF_LOSS: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        s_mf_fourth |=> crc_mf_loss_status && frame_loss_status)
        else $error("pattern loss not declared");
    AST_MF_KEEP: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.ctl[0] && !st_r.crc_lost && frame_lock_in && !excess_crc_in) |=> !st_r.crc_lost)
        else $error("crc multiframe lost while held");
    AST_REFRAME: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        s_search_end |=> reframe_out == !$past(st_r.ctl[1]))
        else $error("search timer reframe wrong");
    AST_NO_REFRAME: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        st_r.ctl[1] |=> !reframe_out)
        else $error("reframe while timer disabled");
    AST_SLOT16: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (slot16_stb_in && slot16_byte_in == 8'hFF && sig_mf_loss_status &&
         st_r.s16_cnt != 2'h0) |=> st_r.s16_stat)
        else $error("slot16 ones not detected");
    AST_FRM_EDGE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        ($changed(frame_loss_status) && $past(arst_n_in)) |=> st_r.frm_ind[6])
        else $error("frame loss change not flagged");
    AST_RED_FOLLOW: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        $changed(red_lvl) |-> red_lvl == $past(frame_loss_status))
        else $error("sustained loss moved against its source");
    AST_AIS_FOLLOW: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        $changed(ais_lvl) |-> ais_lvl == $past(ones_cond_in && frame_loss_status))
        else $error("all ones alarm moved against its source");
endmodule

// file: efa_stream_model.sv
`timescale 1ns/100ps
// far terminal: one-cycle strobes; data lines flip once the strobe ends so
// a stale value is never mistaken for a fresh one
module efa_stream_model
    import efa_pkg::*;
(
    input  wire logic             mclk_in,
    output logic                  rx_bit_out,
    output logic                  bit_stb_out,
    output logic                  nfas_stb_out,
    output logic                  mf0_stb_out,
    output logic                  slot16_stb_out,
    output logic                  si_stb_out,
    output efa_pkg::efa_byte_type slot16_byte_out
);
    import efa_pkg::*;
    initial begin
        {rx_bit_out, bit_stb_out, nfas_stb_out, mf0_stb_out} = 4'h0;
        {slot16_stb_out, si_stb_out} = 2'h0;
        slot16_byte_out = 8'h00;
    end
    // sel: 0 line bit, 1 nfas A bit, 2 frame0 slot16, 3 slot16, 4 Si bit
    task automatic send(input int sel, input logic [7:0] val);
        @(posedge mclk_in);
        rx_bit_out      <= val[0];
        slot16_byte_out <= val;
        bit_stb_out     <= (sel == 0);
        nfas_stb_out    <= (sel == 1);
        mf0_stb_out     <= (sel == 2);
        slot16_stb_out  <= (sel == 3);
        si_stb_out      <= (sel == 4);
        @(posedge mclk_in);
        {bit_stb_out, nfas_stb_out, mf0_stb_out} <= 3'h0;
        {slot16_stb_out, si_stb_out} <= 2'h0;
        rx_bit_out      <= ~val[0];
        slot16_byte_out <= ~val;
    endtask
endmodule

// file: efa_alarm_tb.sv
`timescale 1ns/100ps
module efa_alarm_tb;
    import efa_pkg::*;
    logic          mclk_in = 1'b0;
    logic          arst_n_in = 1'b0;
    logic [7:0]    addr = 8'h00;
    efa_byte_type  wdata = 8'h00;
    logic          wr = 1'b0;
    logic          rd = 1'b0;
    efa_byte_type  rdata;
    logic          s_bit, s_bstb, s_nstb, s_mstb, s_tstb, s_istb;
    efa_byte_type  s_byte;
    logic          frame_lock = 1'b1;
    logic          sig_lock = 1'b1;
    logic          ones = 1'b0;
    logic          deb_a = 1'b0;
    logic          deb_y = 1'b0;
    logic [6:0]    pls = 7'h00;
    efa_byte_type  fen = 8'h00;
    logic          reframe, irq;
    int            err_total = 0;
    int            checks_done = 0;

    always #2.5 mclk_in = ~mclk_in;

    efa_stream_model u_efa_stream_model (.mclk_in(mclk_in), .rx_bit_out(s_bit),
        .bit_stb_out(s_bstb), .nfas_stb_out(s_nstb), .mf0_stb_out(s_mstb),
        .slot16_stb_out(s_tstb), .si_stb_out(s_istb), .slot16_byte_out(s_byte));

    efa_alarm #(.HOLD_CYC(50), .SEARCH_CYC(40)) u_efa_alarm (.mclk_in(mclk_in),
        .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .rx_bit_in(s_bit), .bit_stb_in(s_bstb), .nfas_stb_in(s_nstb),
        .mf0_stb_in(s_mstb), .slot16_stb_in(s_tstb), .slot16_byte_in(s_byte),
        .si_stb_in(s_istb), .frame_lock_in(frame_lock), .sig_mf_lock_in(sig_lock),
        .crc_mf_found_in(pls[0]), .align_move_in(pls[1]), .fas_err_in(pls[2]),
        .sig_pat_err_in(pls[3]), .crc_pat_err_in(pls[4]), .crc_mismatch_in(pls[5]),
        .excess_crc_in(pls[6]), .ones_cond_in(ones), .far_alarm_debounce_in(deb_a),
        .far_mf_alarm_debounce_in(deb_y), .frame_irq_en_in(fen),
        .reframe_out(reframe), .irq_out(irq));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    task automatic do_reset();
        @(posedge mclk_in);
        arst_n_in <= 1'b0;
        idle(3);
        arst_n_in <= 1'b1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string nm, input logic [7:0] a, m, exp);
        @(posedge mclk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1 chk(nm, rdata & m, exp);
    endtask

    task automatic pulse(input int i);
        @(posedge mclk_in);
        pls[i] <= 1'b1;
        @(posedge mclk_in);
        pls <= 7'h00;
    endtask

    task automatic t_timer();
        int n;
        for (int p = 0; p < 2; p++) begin
            do_reset();
            if (p == 1)
                wr_reg(8'h26, 8'h02);
            n = 0;
            repeat (60) begin
                @(posedge mclk_in);
                #1 n += int'(reframe === 1'b1);
            end
            chk("reframe", 8'(n != 0), 8'(p == 0));
        end
        rd_chk("frm stat", 8'h26, 8'hFF, 8'h12);
        rd_chk("alm en", 8'h23, 8'hFF, 8'h00);
        rd_chk("alm ind", 8'h25, 8'hFF, 8'h00);
        pulse(0);
        idle(2);
        rd_chk("frm stat", 8'h26, 8'hFF, 8'h02);
        rd_chk("frm ind", 8'h24, 8'h10, 8'h10);
        rd_chk("frm ind", 8'h24, 8'hFF, 8'h00);
        wr_reg(8'h26, 8'hFF);
        rd_chk("frm ctl", 8'h26, 8'hFF, 8'h03);
        wr_reg(8'h26, 8'h00);
        $display("test timer done");
    endtask

    task automatic t_regs();
        wr_reg(8'h23, 8'hA5);
        rd_chk("alm en", 8'h23, 8'hFF, 8'hA5);
        wr_reg(8'h22, 8'hFF);
        rd_chk("unmapped", 8'h22, 8'hFF, 8'h00);
        wr_reg(8'h27, 8'hFF);
        rd_chk("alm stat", 8'h27, 8'hFF, 8'h00);
        wr_reg(8'h23, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_events();
        for (int i = 1; i < 6; i++)
            pulse(i);
        u_efa_stream_model.send(4, 8'h00);
        u_efa_stream_model.send(4, 8'h01);
        idle(2);
        chk("irq off", {7'h00, irq}, 8'h00);
        rd_chk("frm ind", 8'h24, 8'hFF, 8'h0F);
        rd_chk("alm ind", 8'h25, 8'hFF, 8'h03);
        wr_reg(8'h23, 8'h03);
        u_efa_stream_model.send(4, 8'h00);
        idle(2);
        chk("irq si", {7'h00, irq}, 8'h01);
        rd_chk("alm ind", 8'h25, 8'hFF, 8'h02);
        chk("irq clr", {7'h00, irq}, 8'h00);
        pulse(5);
        idle(2);
        chk("irq crc", {7'h00, irq}, 8'h01);
        rd_chk("alm ind", 8'h25, 8'hFF, 8'h01);
        wr_reg(8'h23, 8'h00);
        fen <= 8'h08;
        pulse(1);
        idle(2);
        chk("irq frm", {7'h00, irq}, 8'h01);
        rd_chk("frm ind", 8'h24, 8'hFF, 8'h08);
        chk("irq clr", {7'h00, irq}, 8'h00);
        fen <= 8'h00;
        $display("test events done");
    endtask

    // b 3: sustained frame loss, b 2: all-ones alarm, which needs frame loss too
    task automatic t_hold(input int b);
        logic [7:0] m;
        m = 8'h01 << b;
        frame_lock <= 1'b0;
        ones       <= (b == 2);
        idle(3);
        rd_chk("frame loss", 8'h26, 8'h40, 8'h40);
        idle(35);
        rd_chk("hold early", 8'h27, m, 8'h00);
        idle(25);
        rd_chk("hold set", 8'h27, m, m);
        frame_lock <= 1'b1;
        ones       <= 1'b0;
        idle(3);
        pulse(0);
        rd_chk("frame back", 8'h26, 8'h40, 8'h00);
        idle(32);
        rd_chk("hold keep", 8'h27, m, m);
        idle(25);
        rd_chk("hold clr", 8'h27, m, 8'h00);
        rd_chk("hold ind", 8'h25, 8'hFF, m | 8'h08);
        rd_chk("frm ind", 8'h24, 8'h40, 8'h40);
        $display("test hold %0d done", b);
    endtask

    // k 0: A bit of nfas frames, k 1: Y bit of frame 0 slot 16
    task automatic t_deb(input int k);
        logic [7:0] m;
        m = (k == 0) ? 8'h80 : 8'h40;
        wr_reg(8'h23, m);
        for (int d = 1; d >= 0; d--) begin
            deb_a <= d[0];
            deb_y <= d[0];
            // far alarm moves only every second frame, so runs stay even
            for (int i = 0; i < 2 + 2 * d; i++)
                u_efa_stream_model.send(1 + k, (k == 0) ? 8'h01 : 8'h04);
            idle(3);
            rd_chk("far set", 8'h27, m, m);
            chk("irq alm", {7'h00, irq}, 8'h01);
            rd_chk("far ind", 8'h25, 8'hFF, m);
            for (int i = 0; i < 1 + d; i++)
                u_efa_stream_model.send(1 + k, 8'h00);
            idle(3);
            rd_chk("far hold", 8'h27, m, m);
            for (int i = 0; i <= d; i++)
                u_efa_stream_model.send(1 + k, 8'h00);
            idle(3);
            rd_chk("far clr", 8'h27, m, 8'h00);
            rd_chk("far ind", 8'h25, 8'hFF, m);
        end
        wr_reg(8'h23, 8'h00);
        $display("test debounce %0d done", k);
    endtask

    task automatic t_line();
        repeat (1024)
            u_efa_stream_model.send(0, 8'h01);
        rd_chk("unframed", 8'h27, 8'h20, 8'h20);
        repeat (1024)
            u_efa_stream_model.send(0, 8'h00);
        rd_chk("unframed", 8'h27, 8'h20, 8'h00);
        rd_chk("unf ind", 8'h25, 8'hFF, 8'h20);
        sig_lock <= 1'b0;
        u_efa_stream_model.send(3, 8'hFF);
        idle(2);
        rd_chk("sig loss", 8'h26, 8'h20, 8'h20);
        rd_chk("slot16 one", 8'h27, 8'h10, 8'h00);
        u_efa_stream_model.send(3, 8'hFF);
        idle(2);
        rd_chk("slot16 two", 8'h27, 8'h10, 8'h10);
        sig_lock <= 1'b1;
        idle(3);
        rd_chk("sig back", 8'h26, 8'h20, 8'h00);
        rd_chk("sig ind", 8'h24, 8'h20, 8'h20);
        $display("test line done");
    endtask

    task automatic t_mfpat();
        for (int p = 0; p < 2; p++) begin
            do_reset();
            pulse(0);
            wr_reg(8'h26, 8'(p == 0));
            repeat (3)
                pulse(4);
            idle(2);
            rd_chk("mf keep", 8'h26, 8'h50, 8'h00);
            pulse((p == 0) ? 4 : 6);
            idle(2);
            rd_chk("mf lost", 8'h26, 8'h50, (p == 0) ? 8'h00 : 8'h10);
            if (p == 0) begin
                do_reset();
                pulse(0);
                repeat (4)
                    pulse(4);
                idle(2);
                rd_chk("mf lost", 8'h26, 8'h50, 8'h50);
            end
        end
        $display("test pattern loss done");
    endtask

    initial begin
        #200000;
        err_total++;
        finish_test();
    end

    initial begin
        t_timer();
        t_regs();
        t_events();
        t_hold(3);
        t_hold(2);
        t_deb(0);
        t_deb(1);
        t_line();
        t_mfpat();
        finish_test();
    end
endmodule
